// >>> rtl/tto_pkg.sv
// package for the timed two-channel output stage
package tto_pkg;
    // ------------------------------------------------------------
    // register map (word-aligned byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TIME_LO  = 8'h00;
    localparam logic [7:0] ADDR_TIME_HI  = 8'h04;
    localparam logic [7:0] ADDR_TARGET   = 8'h08;
    localparam logic [7:0] ADDR_ARM      = 8'h0C;
    localparam logic [7:0] ADDR_INMAP    = 8'h10;
    localparam logic [7:0] ADDR_INPUT_LO = 8'h14;
    localparam logic [7:0] ADDR_INPUT_HI = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;
    localparam logic [7:0] ADDR_LATCH    = 8'h20;

    // ------------------------------------------------------------
    // field layout and codes
    // ------------------------------------------------------------
    localparam int         FB_LVL1        = 0;
    localparam int         FB_HIZ1        = 1;
    localparam int         FB_LVL2        = 2;
    localparam int         FB_HIZ2        = 3;
    localparam logic [7:0] ARM_IDLE       = 8'h00;
    localparam logic [7:0] ARM_GO         = 8'h03;
    localparam logic [1:0] MAP_NONE       = 2'h0;
    localparam logic [1:0] MAP_CLOCK      = 2'h1;
    localparam logic [1:0] MAP_FEEDBACK   = 2'h2;
    localparam logic [15:0] MAP_ENTRY_CLK = 16'h1A00;
    localparam logic [15:0] REV_CLOCK     = 16'h0016;
    localparam logic [15:0] REV_FEEDBACK  = 16'h0018;
    localparam logic [3:0] TARGET_RST     = 4'h0;
    localparam logic [63:0] TIME_RST      = 64'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TIME_STEP_NS  = 1;

    typedef struct packed {
        logic [63:0] sw_time;
        logic [3:0]  target;
    } tto_sched_t;

    typedef enum logic [2:0] {
        TTO_IDLE  = 3'b001,
        TTO_READY = 3'b010,
        TTO_ARMED = 3'b100
    } tto_state_t;
endpackage

// >>> rtl/tto_timed_output.sv
// timed two-channel output stage with wishbone register slave
`timescale 1ns/1ps

// Functional notes
// [R1] accept new time only on arm 0 to 3
// [R2] switch time held as 64-bit value
// [R3] per-channel level bit selects low/high
// [R4] per-channel bit selects high impedance
// [R5] optional clock snapshot from revision 0016
// [R6] optional feedback byte from revision 0018
// [R7] snapshot and feedback mutually exclusive
// [R8] snapshot enabled by mapping entry 0x1A00
// [R9] snapshot latched before frame collects it
// [R10] master schedules two cycles ahead
// [R11] first cycle: time, targets, arm 0
// [R12] second cycle: arm set to 3
// [R13] master holds arm and targets
// [R14] new schedule only after event completes
// [R15] master adds two-three cycle margin
// [R16] report per-datagram processing state
// [R17] on time match pulse, apply four bits
// [R18] feedback bits: lvl1 hiz1 lvl2 hiz2
// [R19] new arm replaces pending schedule
// [R20] supply loss discards armed time
// [R21] steady 3 or other never re-arms
// [R22] 64-bit ns time, full compare
module tto_timed_output #(
    parameter logic [15:0] HW_REVISION = 16'h0018,
    parameter int          TIME_W      = 64
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [TIME_W-1:0] local_time_i,
    input  wire logic              frame_latch_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    output logic [1:0]             ch_level_o,
    output logic [1:0]             ch_hiz_o,
    output logic                   compare_match_pulse_o,
    output logic                   datagram_processing_state_o
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic hit;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr  = req & wb_we_i & hit;

    always_comb begin
        case (wb_adr_i)
            tto_pkg::ADDR_TIME_LO, tto_pkg::ADDR_TIME_HI, tto_pkg::ADDR_TARGET,
            tto_pkg::ADDR_ARM, tto_pkg::ADDR_INMAP, tto_pkg::ADDR_INPUT_LO,
            tto_pkg::ADDR_INPUT_HI, tto_pkg::ADDR_STATUS, tto_pkg::ADDR_LATCH: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // staged process data from master
    // ------------------------------------------------------------
    tto_pkg::tto_sched_t stage_q, stage_d;
    tto_pkg::tto_sched_t armed_q, armed_d;
    logic [7:0]          arm_q, arm_d;
    logic [7:0]          arm_prev_q, arm_prev_d;
    logic [1:0]          map_q, map_d;
    logic [3:0]          applied_q, applied_d;
    logic [TIME_W-1:0]   snap_q, snap_d;
    tto_pkg::tto_state_t st_q, st_d;
    logic                match_q, match_d;
    logic                dps_q, dps_d;
    logic                arm_edge;
    logic                hit_time;
    logic                snap_ok;
    logic                fb_ok;

    assign snap_ok  = HW_REVISION >= tto_pkg::REV_CLOCK;     // [R5]
    assign fb_ok    = HW_REVISION >= tto_pkg::REV_FEEDBACK;  // [R6]
    // only a fresh 0 -> 3 step arms; holding 3 is not an edge
    assign arm_edge = (arm_prev_q == tto_pkg::ARM_IDLE) && (arm_q == tto_pkg::ARM_GO); // [R1] [R21]
    // full 64-bit compare: a time that only matches in the low word must never fire
    assign hit_time = (st_q == tto_pkg::TTO_ARMED) && (local_time_i == armed_q.sw_time); // [R17] [R22]

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        stage_d    = stage_q;
        arm_d      = arm_q;
        arm_prev_d = arm_q;
        map_d      = map_q;
        armed_d    = armed_q;
        applied_d  = applied_q;
        snap_d     = snap_q;
        st_d       = st_q;
        match_d    = 1'b0;
        dps_d      = dps_q;
        if (wr) begin
            case (wb_adr_i)
                tto_pkg::ADDR_TIME_LO: begin
                    if (wb_sel_i[0]) stage_d.sw_time[7:0]   = wb_dat_i[7:0];
                    if (wb_sel_i[1]) stage_d.sw_time[15:8]  = wb_dat_i[15:8];
                    if (wb_sel_i[2]) stage_d.sw_time[23:16] = wb_dat_i[23:16];
                    if (wb_sel_i[3]) stage_d.sw_time[31:24] = wb_dat_i[31:24];
                end
                tto_pkg::ADDR_TIME_HI: begin
                    if (wb_sel_i[0]) stage_d.sw_time[39:32] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) stage_d.sw_time[47:40] = wb_dat_i[15:8];
                    if (wb_sel_i[2]) stage_d.sw_time[55:48] = wb_dat_i[23:16];
                    if (wb_sel_i[3]) stage_d.sw_time[63:56] = wb_dat_i[31:24];
                end
                tto_pkg::ADDR_TARGET: begin
                    if (wb_sel_i[0]) stage_d.target = wb_dat_i[3:0]; // [R3] [R4]
                end
                tto_pkg::ADDR_ARM: begin
                    if (wb_sel_i[0]) arm_d = wb_dat_i[7:0];
                end
                tto_pkg::ADDR_INMAP: begin
                    // one input object at a time; unsupported choice falls back to none
                    if (wb_sel_i[0]) begin
                        if (wb_dat_i[1:0] == tto_pkg::MAP_CLOCK && snap_ok) begin
                            map_d = tto_pkg::MAP_CLOCK;    // [R7] [R8]
                        end else if (wb_dat_i[1:0] == tto_pkg::MAP_FEEDBACK && fb_ok) begin
                            map_d = tto_pkg::MAP_FEEDBACK; // [R7]
                        end else begin
                            map_d = tto_pkg::MAP_NONE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (req && !hit) begin
            dps_d = 1'b0;                                  // [R16]
        end
        // frame latch strobe: sample time ahead of the frame read; a write to the latch register also counts
        // a latch in the same cycle as a bad access wins, so a fresh snapshot is never reported as stale
        if (frame_latch_i || (wr && wb_adr_i == tto_pkg::ADDR_LATCH)) begin
            snap_d = local_time_i;                         // [R9]
            dps_d  = 1'b1;                                 // [R16]
        end
        case (st_q)
            tto_pkg::TTO_IDLE: begin
                if (arm_edge) st_d = tto_pkg::TTO_ARMED;
            end
            tto_pkg::TTO_READY: begin
                if (arm_edge) st_d = tto_pkg::TTO_ARMED;
            end
            tto_pkg::TTO_ARMED: begin
                if (hit_time) begin
                    applied_d = armed_q.target;            // [R17]
                    match_d   = 1'b1;
                    st_d      = tto_pkg::TTO_READY;
                end
            end
            default: st_d = tto_pkg::TTO_IDLE;
        endcase
        // a fresh arm overwrites whatever is pending, even if in the past
        if (arm_edge) begin
            armed_d = stage_q;                             // [R1] [R19] [R2]
            // an event due in this very cycle still fires; the new schedule waits behind it
            st_d    = tto_pkg::TTO_ARMED;                  // [R19]
        end
    end

    // reset models supply loss: armed time is gone afterwards
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage_q    <= '{sw_time: tto_pkg::TIME_RST, target: tto_pkg::TARGET_RST};
            armed_q    <= '{sw_time: tto_pkg::TIME_RST, target: tto_pkg::TARGET_RST}; // [R20]
            arm_q      <= tto_pkg::ARM_IDLE;
            arm_prev_q <= tto_pkg::ARM_IDLE;
            map_q      <= tto_pkg::MAP_NONE;
            applied_q  <= tto_pkg::TARGET_RST;
            snap_q     <= tto_pkg::TIME_RST;
            st_q       <= tto_pkg::TTO_IDLE;                                        // [R20]
            match_q    <= 1'b0;
            dps_q      <= 1'b0;
        end else begin
            stage_q    <= stage_d;
            armed_q    <= armed_d;
            arm_q      <= arm_d;
            arm_prev_q <= arm_prev_d;
            map_q      <= map_d;
            applied_q  <= applied_d;
            snap_q     <= snap_d;
            st_q       <= st_d;
            match_q    <= match_d;
            dps_q      <= dps_d;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    logic [31:0] rdata_d, rdata_q;
    logic        ack_q, err_q;
    logic        ack_d, err_d;
    logic [7:0]  feedback;
    assign feedback = {4'h0, applied_q[tto_pkg::FB_HIZ2], applied_q[tto_pkg::FB_LVL2],
                       applied_q[tto_pkg::FB_HIZ1], applied_q[tto_pkg::FB_LVL1]}; // [R18] [R6]

    // registered answer costs one cycle but keeps the bus outputs free of glitches
    always_comb begin
        ack_d   = req & hit;
        err_d   = req & ~hit;
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            tto_pkg::ADDR_TIME_LO:  rdata_d = stage_q.sw_time[31:0];
            tto_pkg::ADDR_TIME_HI:  rdata_d = stage_q.sw_time[63:32];
            tto_pkg::ADDR_TARGET:   rdata_d = {28'h0000000, stage_q.target};
            tto_pkg::ADDR_ARM:      rdata_d = {24'h000000, arm_q};
            tto_pkg::ADDR_INMAP:    rdata_d = {tto_pkg::MAP_ENTRY_CLK, 14'h0000, map_q};
            tto_pkg::ADDR_INPUT_LO: begin
                if (map_q == tto_pkg::MAP_CLOCK) rdata_d = snap_q[31:0];      // [R5] [R7]
                else if (map_q == tto_pkg::MAP_FEEDBACK) rdata_d = {24'h000000, feedback};
            end
            tto_pkg::ADDR_INPUT_HI: begin
                if (map_q == tto_pkg::MAP_CLOCK) rdata_d = snap_q[63:32];
            end
            tto_pkg::ADDR_STATUS:   rdata_d = {24'h000000, dps_q, 4'h0, st_q};  // [R16]
            default:                rdata_d = 32'h0000_0000;
        endcase
        // read data holds between requests so the master can pick it up late
        if (!req) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
        end
    end

    assign wb_dat_o                    = rdata_q;
    assign wb_ack_o                    = ack_q;
    assign wb_err_o                    = err_q;
    assign ch_level_o                  = {applied_q[tto_pkg::FB_LVL2], applied_q[tto_pkg::FB_LVL1]}; // [R3]
    assign ch_hiz_o                    = {applied_q[tto_pkg::FB_HIZ2], applied_q[tto_pkg::FB_HIZ1]}; // [R4]
    assign compare_match_pulse_o       = match_q;
    assign datagram_processing_state_o = dps_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence arm_step_s;
        arm_prev_q == tto_pkg::ARM_IDLE ##0 arm_q == tto_pkg::ARM_GO;
    endsequence

    sequence answer_s;
        (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
    endsequence

    arm_takes_time_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R1]
        arm_step_s |=> armed_q == $past(stage_q))
        else $error("armed schedule not taken on arm step");
    hold_no_rearm_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R21]
        !arm_edge |=> armed_q == $past(armed_q))
        else $error("schedule changed without arm step");
    match_applies_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R17]
        hit_time |=> compare_match_pulse_o && {ch_hiz_o[1], ch_level_o[1], ch_hiz_o[0], ch_level_o[0]}
                     == $past(armed_q.target))
        else $error("match did not apply targets");
    pulse_one_cycle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R17]
        compare_match_pulse_o |=> !compare_match_pulse_o)
        else $error("match pulse longer than one cycle");
    outputs_stable_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R3]
        !compare_match_pulse_o |-> $stable(ch_level_o) && $stable(ch_hiz_o))
        else $error("outputs changed without match");
    armed_replace_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R19]
        arm_edge |=> st_q == tto_pkg::TTO_ARMED)
        else $error("fresh arm did not arm");
    ready_after_match_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R17]
        hit_time && !arm_edge |=> st_q == tto_pkg::TTO_READY)
        else $error("schedule still armed after match");
    no_idle_match_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R17]
        st_q != tto_pkg::TTO_ARMED |=> !compare_match_pulse_o)
        else $error("match pulse without armed schedule");
    time_lo_stage_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R2]
        wr && wb_adr_i == tto_pkg::ADDR_TIME_LO && wb_sel_i == 4'hF |=> stage_q.sw_time[31:0] == $past(wb_dat_i))
        else $error("low time word not staged");
    time_hi_stage_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R2]
        wr && wb_adr_i == tto_pkg::ADDR_TIME_HI && wb_sel_i == 4'hF |=> stage_q.sw_time[63:32] == $past(wb_dat_i))
        else $error("high time word not staged");
    target_stage_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R3]
        wr && wb_adr_i == tto_pkg::ADDR_TARGET && wb_sel_i[0] |=> stage_q.target == $past(wb_dat_i[3:0]))
        else $error("target bits not staged");
    snap_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R9]
        frame_latch_i |=> snap_q == $past(local_time_i))
        else $error("snapshot not latched");

    // ------------------------------------------------------------
    // checks: bus and input data
    // ------------------------------------------------------------
    map_exclusive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R7]
        wb_ack_o && $past(wb_adr_i) == tto_pkg::ADDR_INPUT_HI && $past(map_q) != tto_pkg::MAP_CLOCK
            |-> wb_dat_o == 32'h0000_0000)
        else $error("snapshot word visible while not mapped");
    feedback_layout_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R18]
        wb_ack_o && $past(wb_adr_i) == tto_pkg::ADDR_INPUT_LO && $past(map_q) == tto_pkg::MAP_FEEDBACK
            && !compare_match_pulse_o
            |-> wb_dat_o[7:0] == {4'h0, ch_hiz_o[1], ch_level_o[1], ch_hiz_o[0], ch_level_o[0]})
        else $error("feedback layout wrong");
    snap_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R5]
        wb_ack_o && $past(wb_adr_i) == tto_pkg::ADDR_INPUT_LO && $past(map_q) == tto_pkg::MAP_CLOCK
            |-> wb_dat_o == $past(snap_q[31:0]))
        else $error("snapshot low word wrong");
    map_entry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R8]
        wb_ack_o && $past(wb_adr_i) == tto_pkg::ADDR_INMAP |-> wb_dat_o[31:16] == tto_pkg::MAP_ENTRY_CLK)
        else $error("mapping entry wrong");
    rev_clock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R5]
        map_q == tto_pkg::MAP_CLOCK |-> snap_ok)
        else $error("snapshot mapped on old revision");
    rev_feedback_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R6]
        map_q == tto_pkg::MAP_FEEDBACK |-> fb_ok)
        else $error("feedback mapped on old revision");
    dps_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R16]
        frame_latch_i |=> datagram_processing_state_o)
        else $error("processing state not set by latch");
    dps_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R16]
        req && !hit && !frame_latch_i |=> !datagram_processing_state_o)
        else $error("processing state not cleared by bad access");
    err_unmapped_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R16]
        req && !hit |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R16]
        req |=> answer_s)
        else $error("bus answer not single cycle");
endmodule

// >>> test/tto_master_model.sv
// fieldbus master side model: distributed time base and frame latch
`timescale 1ns/1ps
module tto_master_model #(
    parameter logic [63:0] START_TIME = 64'h0000_0002_0000_0000
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        latch_req_i,
    output logic [63:0]      local_time_o,
    output logic             frame_latch_o,
    output logic [63:0]      snap_o
);
    logic [63:0] time_q;
    logic [63:0] time_d;
    logic        latch_q;
    logic [63:0] snap_q;
    logic [63:0] snap_d;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    // the clock keeps running across a device supply loss, so it has its own reset
    always_comb begin
        time_d = time_q + 64'(tto_pkg::CLK_PERIOD_NS / tto_pkg::TIME_STEP_NS);
        snap_d = latch_q ? time_q : snap_q;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            time_q  <= START_TIME;
            latch_q <= 1'b0;
            snap_q  <= 64'h0;
        end else begin
            time_q  <= time_d;
            latch_q <= latch_req_i;
            snap_q  <= snap_d;
        end
    end

    assign local_time_o  = time_q;
    assign frame_latch_o = latch_q;
    assign snap_o        = snap_q;
endmodule

// >>> test/timed_two_channel_output_bench.sv
// self-checking bench for the timed two-channel output stage
`timescale 1ns/1ps
module timed_two_channel_output_bench;
    localparam logic [63:0] STEP = 64'(tto_pkg::CLK_PERIOD_NS);
    logic        ref_clk, rst_n, boot_n, latch_req, flatch;
    logic        cyc, stb, we, ack, err, pulse, dstate, er, seen;
    logic [7:0]  adr;
    logic [31:0] dat, rdat, q;
    logic [1:0]  level, hiz;
    logic [63:0] now, snap, t;
    logic [3:0]  tgs [3] = '{4'h9, 4'h6, 4'hF};
    int          n_mismatch, comparisons;

    tto_master_model PEER (.ref_clk_i(ref_clk), .rst_n_i(boot_n), .latch_req_i(latch_req),
        .local_time_o(now), .frame_latch_o(flatch), .snap_o(snap));

    tto_timed_output DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .local_time_i(now), .frame_latch_i(flatch),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .ch_level_o(level), .ch_hiz_o(hiz),
        .compare_match_pulse_o(pulse), .datagram_processing_state_o(dstate));

    task automatic check(input string what, input logic [63:0] seen_v, input logic [63:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            n_mismatch++;
            $display("BAD %0s expected %0h seen %0h", what, exp_v, seen_v);
        end
    endtask

    task automatic print_verdict();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus access: hold the request until the answer is sampled
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        // read just after an edge, ack and data are the values sampled at that edge
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q  = rdat;
        er = err;
        check("bus answer", ack ^ err, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic sched(input logic [63:0] tm, input logic [3:0] tg, input logic go);
        wb(1'b1, tto_pkg::ADDR_TIME_LO, tm[31:0]);
        wb(1'b1, tto_pkg::ADDR_TIME_HI, tm[63:32]);
        wb(1'b1, tto_pkg::ADDR_TARGET, {28'h0, tg});
        if (go) begin
            wb(1'b1, tto_pkg::ADDR_ARM, {24'h0, tto_pkg::ARM_IDLE});
            wb(1'b1, tto_pkg::ADDR_ARM, {24'h0, tto_pkg::ARM_GO});
        end
    endtask

    task automatic wait_pulse(input int cycles);
        seen = 1'b0;
        for (int i = 0; i < cycles && !seen; i++) begin
            @(negedge ref_clk);
            seen = (pulse === 1'b1);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // bound far above the roughly 1000 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {rst_n, boot_n, latch_req, cyc, stb, we, adr, dat} = '0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (10) @(posedge ref_clk);
        rst_n  <= 1'b1;
        boot_n <= 1'b1;
        @(negedge ref_clk);
        check("reset levels", {level, hiz, pulse}, 5'h00);
        wb(1'b0, tto_pkg::ADDR_STATUS, 32'h0);
        check("reset state", q[2:0], 3'h1);
        $display("test reset done");
        // schedules 60 cycles ahead, well beyond the two-cycle handshake margin
        foreach (tgs[i]) begin
            t = now + STEP * 64'h3C;
            sched(t, tgs[i], 1'b1);
            wait_pulse(200);
            check("match pulse", seen, 1'b1);
            check("match time", now, t + STEP * 64'h1);
            check("levels", level, {tgs[i][2], tgs[i][0]});
            check("hiz", hiz, {tgs[i][3], tgs[i][1]});
            wb(1'b1, tto_pkg::ADDR_INMAP, {30'h0, tto_pkg::MAP_FEEDBACK});
            wb(1'b0, tto_pkg::ADDR_INPUT_LO, 32'h0);
            check("feedback", q[7:0], {4'h0, tgs[i]});
        end
        $display("test schedule done");
        // arm held at 3, then 1 to 3: neither is a fresh 0 to 3
        sched(now + STEP * 64'h3C, 4'h0, 1'b0);
        wb(1'b1, tto_pkg::ADDR_ARM, {24'h0, tto_pkg::ARM_GO});
        wb(1'b1, tto_pkg::ADDR_ARM, 32'h1);
        wb(1'b1, tto_pkg::ADDR_ARM, {24'h0, tto_pkg::ARM_GO});
        wait_pulse(150);
        check("no rearm pulse", seen, 1'b0);
        check("no rearm levels", {level, hiz}, 4'hF);
        wb(1'b0, tto_pkg::ADDR_STATUS, 32'h0);
        check("no rearm state", q[2:0], 3'h2);
        $display("test steady arm done");
        sched(now + STEP * 64'h50, 4'h0, 1'b1);
        sched(now - STEP * 64'hA, 4'h5, 1'b1);
        wait_pulse(150);
        check("cancel pulse", seen, 1'b0);
        check("cancel levels", {level, hiz}, 4'hF);
        sched(now + STEP * 64'h3C + 64'h1_0000_0000, 4'h0, 1'b1);
        wait_pulse(120);
        check("upper word compare", seen, 1'b0);
        $display("test replace done");
        wb(1'b1, tto_pkg::ADDR_INMAP, {30'h0, tto_pkg::MAP_CLOCK});
        wb(1'b0, tto_pkg::ADDR_INMAP, 32'h0);
        check("map entry", q[31:16], tto_pkg::MAP_ENTRY_CLK);
        check("map choice", q[1:0], tto_pkg::MAP_CLOCK);
        @(posedge ref_clk);
        latch_req <= 1'b1;
        @(posedge ref_clk);
        latch_req <= 1'b0;
        wb(1'b0, tto_pkg::ADDR_INPUT_LO, 32'h0);
        check("snapshot lo", q, snap[31:0]);
        wb(1'b0, tto_pkg::ADDR_INPUT_HI, 32'h0);
        check("snapshot hi", q, snap[63:32]);
        wb(1'b0, tto_pkg::ADDR_STATUS, 32'h0);
        check("state after latch", q[7], 1'b1);
        check("state pin set", dstate, 1'b1);
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped error", er, 1'b1);
        wb(1'b0, tto_pkg::ADDR_STATUS, 32'h0);
        check("state after error", q[7], 1'b0);
        check("state pin clear", dstate, 1'b0);
        wb(1'b1, tto_pkg::ADDR_INMAP, {30'h0, tto_pkg::MAP_FEEDBACK});
        wb(1'b0, tto_pkg::ADDR_INPUT_LO, 32'h0);
        check("exclusive input", q[7:0], 8'h0F);
        wb(1'b0, tto_pkg::ADDR_INPUT_HI, 32'h0);
        check("exclusive hi", q, 32'h0);
        wb(1'b1, tto_pkg::ADDR_INMAP, 32'h3);
        wb(1'b0, tto_pkg::ADDR_INMAP, 32'h0);
        check("map fallback", q[1:0], tto_pkg::MAP_NONE);
        $display("test inputs done");
        sched(now + STEP * 64'h64, 4'hA, 1'b1);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check("loss levels", {level, hiz}, 4'h0);
        wb(1'b0, tto_pkg::ADDR_STATUS, 32'h0);
        check("loss state", q[2:0], 3'h1);
        wait_pulse(200);
        check("loss pulse", seen, 1'b0);
        $display("test supply loss done");
        print_verdict();
    end
endmodule
